// file: verilog/rpr_pkg.sv
// constants and state types shared by both ends of the registered read-only memory link
// ==========================================================================
package rpr_pkg;

  // ========================================================================
  // array shape
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int WORDS = 512;
  localparam logic [DATA_W-1:0] DATA_ONES = 8'h00FF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h0000;

  // ========================================================================
  // timing: ref clock period and worst-case address setup, in ns
  localparam int CLK_PERIOD_NS = 40;
  localparam int ADDR_SETUP_NS = 60;
  // least time, so round up
  localparam int SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0000;

  // ========================================================================
  // device end state
  typedef struct packed {
    logic clk_prev;
    logic disabled;
    logic [DATA_W-1:0] data;
  } rpr_dev_state_type;

  localparam rpr_dev_state_type DEV_RESET = '{clk_prev: 1'b0, disabled: 1'b1, data: 8'h0000};

  // ========================================================================
  // controller end state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_HIGH = 2'b10
  } rpr_ctrl_phase_type;

  typedef struct packed {
    rpr_ctrl_phase_type phase;
    logic [CNT_W-1:0] cnt;
    logic clk;
    logic [ADDR_W-1:0] addr;
    logic sync_n;
    logic [DATA_W-1:0] data;
    logic driven;
    logic valid;
  } rpr_ctrl_state_type;

  localparam rpr_ctrl_state_type CTRL_RESET = '{phase: ST_IDLE, cnt: 4'h0000, clk: 1'b0,
    addr: 9'h0000, sync_n: 1'b1, data: 8'h0000, driven: 1'b0, valid: 1'b0};

endpackage

// file: verilog/rpr_link_if.sv
// interface joining the memory device end and its controller end
`timescale 1ns/10ps
`default_nettype none

interface rpr_link_if;
  import rpr_pkg::*;
  logic register_clock;
  logic [ADDR_W-1:0] word_addr;
  logic sync_enable_n;
  logic async_enable_n;
  logic register_preset_n;
  logic register_clear_n;
  logic [DATA_W-1:0] data_out;
  logic [DATA_W-1:0] data_oe;

  modport device (
    input register_clock, word_addr, sync_enable_n, async_enable_n,
    input register_preset_n, register_clear_n,
    output data_out, data_oe
  );

  modport ctrl (
    output register_clock, word_addr, sync_enable_n, async_enable_n,
    output register_preset_n, register_clear_n,
    input data_out, data_oe
  );
endinterface

`default_nettype wire

// file: verilog/rpr_device.sv
// device end: fuse array with edge-triggered output register and enables
`timescale 1ns/10ps
`default_nettype none

module rpr_device
  import rpr_pkg::*;
#(
  // fuse pattern, word n at bits n*8+7..n*8; all zero is a blank part
  parameter logic [WORDS*DATA_W-1:0] FUSE_MAP = '0
) (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // sync reset, high
  rpr_link_if.device link, // pins toward the controller
  output logic output_active // outputs currently driven
);

  rpr_dev_state_type st_reg;
  rpr_dev_state_type st_next;
  logic clk_rise;
  logic [DATA_W-1:0] word_read;
  logic [DATA_W-1:0] word_shown;
  logic drive;

  // ========================================================================
  // array access
  // word selected by address ahead of the edge
  // blank fuses give zero, programmed give one
  assign word_read = FUSE_MAP[link.word_addr * DATA_W +: DATA_W];
  assign clk_rise = link.register_clock & ~st_reg.clk_prev;

  // ========================================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.clk_prev = link.register_clock;
    if (clk_rise) begin
      st_next.data = word_read;
      st_next.disabled = link.sync_enable_n;
    end
    // clear overrides clock, held at zero
    if (!link.register_clear_n) begin
      st_next.data = DATA_ZERO;
    end else if (!link.register_preset_n) begin
      st_next.data = DATA_ONES;
    end
  end

  // ========================================================================
  // state register; reset stands in for power-up
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= DEV_RESET;
    end else begin
      // stored word changes only on a captured edge or under preset or clear
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // pin drive; preset and clear bypass the register so they act at once
  always_comb begin
    if (!link.register_clear_n) begin
      word_shown = DATA_ZERO;
    end else if (!link.register_preset_n) begin
      word_shown = DATA_ONES;
    end else begin
      word_shown = st_reg.data;
    end
  end

  // both enables must be low to drive
  assign drive = ~st_reg.disabled & ~link.async_enable_n;
  assign link.data_out = word_shown;
  assign link.data_oe = {DATA_W{drive}};
  assign output_active = drive;

endmodule

`default_nettype wire

// file: verilog/rpr_controller.sv
// controller end: makes the register clock and runs single-word reads
`timescale 1ns/10ps
`default_nettype none

module rpr_controller
  import rpr_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // sync reset, high
  rpr_link_if.ctrl link, // pins toward the memory
  input wire logic rd_valid, // read request
  output logic rd_ready, // request can be taken
  input wire logic [ADDR_W-1:0] rd_addr, // word to read
  input wire logic rd_disable, // clock with sync enable high instead
  input wire logic out_enable, // level for the async enable
  input wire logic preset_req, // hold register at ones
  input wire logic clear_req, // hold register at zero
  output logic [DATA_W-1:0] rd_data, // word seen after the edge
  output logic rd_driven, // memory was driving when sampled
  output logic rd_data_valid // one-cycle pulse with rd_data
);

  rpr_ctrl_state_type st_reg;
  rpr_ctrl_state_type st_next;
  logic force_busy;

  // no reads while preset or clear held
  assign force_busy = preset_req | clear_req;
  assign rd_ready = (st_reg.phase == ST_IDLE) & ~force_busy;

  // ========================================================================
  // read sequencer: low half covers address setup, high half waits for data
  always_comb begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    case (st_reg.phase)
      ST_IDLE: begin
        st_next.clk = 1'b0;
        if (rd_valid && rd_ready) begin
          // address out, sync enable low for a read
          st_next.addr = rd_addr;
          st_next.sync_n = rd_disable;
          st_next.cnt = SETUP_LOAD;
          st_next.phase = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (st_reg.cnt == CNT_ZERO) begin
          st_next.clk = 1'b1;
          st_next.cnt = SETUP_LOAD;
          st_next.phase = ST_HIGH;
        end else begin
          st_next.cnt = st_reg.cnt - 4'h0001;
        end
      end
      ST_HIGH: begin
        if (st_reg.cnt == CNT_ZERO) begin
          st_next.clk = 1'b0;
          st_next.data = link.data_oe[0] ? link.data_out : DATA_ZERO;
          st_next.driven = link.data_oe[0];
          st_next.valid = 1'b1;
          st_next.phase = ST_IDLE;
        end else begin
          st_next.cnt = st_reg.cnt - 4'h0001;
        end
      end
      default: begin
        st_next = CTRL_RESET;
      end
    endcase
  end

  // ========================================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // pins; address and sync enable held past the edge, free afterwards
  // inputs left as they were after the edge
  assign link.register_clock = st_reg.clk;
  assign link.word_addr = st_reg.addr;
  assign link.sync_enable_n = st_reg.sync_n;
  // tie out_enable high to leave the async enable always active
  assign link.async_enable_n = ~out_enable;
  // never both: clear takes precedence here
  assign link.register_clear_n = ~clear_req;
  assign link.register_preset_n = ~(preset_req & ~clear_req);
  assign rd_data = st_reg.data;
  assign rd_driven = st_reg.driven;
  assign rd_data_valid = st_reg.valid;

endmodule

`default_nettype wire

// file: verification/rpr_chk.sv
// wire-level checker for the memory link
`timescale 1ns/10ps
`default_nettype none
module rpr_chk
  import rpr_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic register_clock, // reg clock
  input wire logic sync_enable_n, // sync enable
  input wire logic async_enable_n, // async enable
  input wire logic register_preset_n, // preset
  input wire logic register_clear_n, // clear
  input wire logic [DATA_W-1:0] data_out, // data
  input wire logic [DATA_W-1:0] data_oe // enables
);
  // ==========================================================
  // rules
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rise;
    !register_clock ##1 register_clock;
  endsequence
  sequence s_idle;
    register_preset_n && register_clear_n && data_oe[0];
  endsequence
  property p_oe_whole;
    data_oe == 8'h00 || data_oe == 8'hFF;
  endproperty
  property p_async_off;
    async_enable_n |-> data_oe == 8'h00;
  endproperty
  property p_start_off;
    $fell(sys_rst) |-> data_oe == 8'h00;
  endproperty
  property p_off_edge;
    s_rise ##0 sync_enable_n |=> data_oe == 8'h00;
  endproperty
  // enable must be held across the load, so both samples are checked
  property p_on_edge;
    s_rise ##0 (!sync_enable_n && !async_enable_n) ##1 !async_enable_n |-> data_oe == 8'hFF;
  endproperty
  property p_preset;
    !register_preset_n && register_clear_n && data_oe[0] |-> data_out == 8'hFF;
  endproperty
  property p_clear;
    !register_clear_n && data_oe[0] |-> data_out == 8'h00;
  endproperty
  property p_hold;
    (!$rose(register_clock) ##0 s_idle) ##1 s_idle |-> $stable(data_out);
  endproperty
  a_oe_whole: assert property (p_oe_whole) else $error("enables split");
  a_async_off: assert property (p_async_off) else $error("async off ignored");
  a_start_off: assert property (p_start_off) else $error("driving after reset");
  a_off_edge: assert property (p_off_edge) else $error("sync off ignored");
  a_on_edge: assert property (p_on_edge) else $error("not driving after load");
  a_preset: assert property (p_preset) else $error("preset not ones");
  a_clear: assert property (p_clear) else $error("clear not zero");
  a_hold: assert property (p_hold) else $error("data moved between edges");
endmodule
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the memory and controller pair
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rpr_pkg::*;
  logic ref_clk = 0, sys_rst = 1, rd_valid = 0, rd_disable = 0, out_enable = 1;
  logic preset_req = 0, clear_req = 0, rd_ready, rd_driven, rd_data_valid, output_active;
  logic [ADDR_W-1:0] rd_addr = '0;
  logic [DATA_W-1:0] rd_data;
  logic [ADDR_W-1:0] adr [5] = '{9'h000, 9'h001, 9'h0A5, 9'h100, 9'h1FF};
  int fail_count = 0, num_checks = 0;
  // word 0 stays blank, so it reads as zeros
  function automatic logic [DATA_W-1:0] fw(input logic [ADDR_W-1:0] a);
    return {a[3:0], a[8:5]};
  endfunction
  function automatic logic [WORDS*DATA_W-1:0] mk();
    logic [WORDS*DATA_W-1:0] m;
    for (int i = 0; i < WORDS; i++) m[i*DATA_W+:DATA_W] = fw(ADDR_W'(i));
    return m;
  endfunction
  always #20 ref_clk = ~ref_clk;
  rpr_link_if link ();
  rpr_device #(.FUSE_MAP(mk())) u_rpr_device (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .link(link), .output_active(output_active));
  rpr_controller u_rpr_controller (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_disable(rd_disable),
    .out_enable(out_enable), .preset_req(preset_req), .clear_req(clear_req),
    .rd_data(rd_data), .rd_driven(rd_driven), .rd_data_valid(rd_data_valid));
  rpr_chk u_rpr_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .register_clock(link.register_clock), .sync_enable_n(link.sync_enable_n),
    .async_enable_n(link.async_enable_n), .register_preset_n(link.register_preset_n),
    .register_clear_n(link.register_clear_n), .data_out(link.data_out),
    .data_oe(link.data_oe));
  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one read: request held until taken, answer polled with a bound
  task automatic rd(input logic [ADDR_W-1:0] a, input logic dis, input logic [7:0] exp,
    input logic drv);
    int n;
    n = 0;
    @(negedge ref_clk);
    rd_valid = 1;
    rd_addr = a;
    rd_disable = dis;
    while (rd_ready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    rd_valid = 0;
    while (rd_data_valid !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk({6'h00, rd_data_valid, rd_driven, rd_data}, {6'h00, 1'b1, drv, exp});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (12) @(negedge ref_clk);
    sys_rst = 0;
    @(negedge ref_clk);
    chk(16'(output_active), 16'h0000);
    foreach (adr[i]) rd(adr[i], 0, fw(adr[i]), 1);
    // next address goes out before the edge; old word must stay on the pins
    @(negedge ref_clk);
    rd_valid = 1;
    rd_addr = 9'h003;
    @(negedge ref_clk);
    rd_valid = 0;
    @(negedge ref_clk);
    chk({7'h00, link.word_addr}, 16'h0003);
    chk(16'(link.data_out), 16'(fw(9'h1FF)));
    repeat (4) @(negedge ref_clk);
    chk(16'(rd_data), 16'(fw(9'h003)));
    $display("test reads done");
    out_enable = 0;
    @(negedge ref_clk);
    chk(16'(output_active), 16'h0000);
    rd(9'h001, 0, 8'h00, 0);
    out_enable = 1;
    @(negedge ref_clk);
    chk(16'(output_active), 16'h0001);
    rd(9'h002, 1, 8'h00, 0);
    rd(9'h002, 0, fw(9'h002), 1);
    $display("test enables done");
    preset_req = 1;
    @(negedge ref_clk);
    chk({7'h00, rd_ready, link.data_out}, 16'h00FF);
    preset_req = 0;
    clear_req = 1;
    @(negedge ref_clk);
    chk(16'(link.data_out), 16'h0000);
    clear_req = 0;
    rd(9'h1FF, 0, fw(9'h1FF), 1);
    $display("test preset clear done");
    results();
  end
  // watchdog at 4000 cycles, far beyond the hundred or so cycles the tests need
  initial begin
    #(4000 * 40);
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
